//--- verilog/hv_wake_input_monitor.v
// Wake pin monitor: filtering, cyclic sense, bias control, status registers
// Contract
// - Both rising and falling edges on the wake pin are signalled.
// - Edge gives interrupt in Normal/Stop, wake-up in Sleep/Fail-Safe.
// - Control bit selects static sensing or cyclic timed sensing.
// - Static sensing filters the input for nominally 16 us.
// - Filter restarts on each crossing; accept only after quiet interval.
// - Wake capability of the pin is switched by a control bit.
// - Each pin wake event sets the first wake status flag.
// - Pin level is reported in Normal, Stop and Init modes.
// - In cyclic sensing the level status shows the last sample.
// - Alternate wake input uses same filter, reports in second status.
// - Two-bit bias: none, pull-down, pull-up, automatic.
// - Automatic bias pulls up on High level, down on Low level.
// - Cyclic sense samples each high-side on-phase; change is a wake.
// - Measurement mode disables fail output, its test, GPIO and wake.
// - Measurement mode turns bias off and blocks the wake signal.
// - Measurement mode ignores bias and wake settings, writes still land.
// - Measurement mode freezes the event flag; level status reads zero.
// - Sleep attempt with pin as only wake source sets error, restarts; the code does so only in measurement mode.
// - Interrupt raised only when the source is enabled for wake.
`timescale 1ns/1ps
`include "hv_wake_map.vh"

module hv_wake_input_monitor (
  input wire CLOCK,
  input wire RESETN,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  input wire WAKE_COMP,
  input wire GPIO_COMP,
  input wire HS_ON,
  input wire [2:0] CHIP_MODE,
  input wire SLEEP_REQ,
  input wire OTHER_WAKE_EN,
  output reg PULL_UP_EN,
  output reg PULL_DOWN_EN,
  output reg WAKE_IRQ,
  output reg WAKE_UP,
  output reg RESTART_REQ,
  output reg FAIL_OUT_DISABLE,
  output reg GPIO_DISABLE
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  localparam integer FILT_LAST = `FILT_CYCLES - 1;

  // Counter reloads whenever the synced level equals the accepted level,
  // so any crossing back inside the interval restarts the wait.
  function [`FILT_W-1:0] filt_next;
    input differs;
    input [`FILT_W-1:0] cnt;
    begin
      if (!differs) begin
        filt_next = {`FILT_W{1'b0}};
      end else if (cnt == FILT_LAST) begin
        filt_next = {`FILT_W{1'b0}};
      end else begin
        filt_next = cnt + 1'b1;
      end
    end
  endfunction

  function filt_done;
    input differs;
    input [`FILT_W-1:0] cnt;
    begin
      filt_done = differs && (cnt == FILT_LAST);
    end
  endfunction

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg [`CTL_WIDTH-1:0] ctl_r;
  reg [`BIAS_WIDTH-1:0] bias_r;
  reg pin_flag_r;
  reg gpio_flag_r;
  reg cmd_err_r;
  reg level_r;
  reg pin_meta_r;
  reg pin_sync_r;
  reg gpio_meta_r;
  reg gpio_sync_r;
  reg pin_stable_r;
  reg gpio_stable_r;
  reg [`FILT_W-1:0] pin_cnt_r;
  reg [`FILT_W-1:0] gpio_cnt_r;
  reg hs_on_d_r;
  reg sample_r;
  reg sample_valid_r;

  wire meas;
  wire pin_wake_en;
  wire gpio_wake_en;
  wire cyclic;
  wire pin_diff;
  wire gpio_diff;
  wire static_evt;
  wire gpio_evt;
  wire sample_now;
  wire cyclic_evt;
  wire pin_evt;
  wire irq_mode;
  wire wake_mode;
  wire lvl_mode;
  wire sense_level;
  wire access;
  wire wr_take;
  wire wr_lane;
  wire clr_first;
  wire clr_second;
  wire clr_err;
  wire sleep_refused;
  wire pin_wake;
  wire gpio_wake;
  wire any_wake;

  // --------------------------------------------------------------------
  // Configuration decode
  // --------------------------------------------------------------------
  assign meas = ctl_r[`CTL_MEAS_EN];
  // Settings are held but overridden while measuring
  assign pin_wake_en = ctl_r[`CTL_PIN_WAKE_EN] && !meas;
  assign gpio_wake_en = ctl_r[`CTL_GPIO_WAKE_EN] &&
                        ctl_r[`CTL_GPIO_AS_WAKE] && !meas;
  assign cyclic = ctl_r[`CTL_CYCLIC_SEL];

  assign irq_mode = (CHIP_MODE == `MODE_NORMAL) ||
                    (CHIP_MODE == `MODE_STOP);
  assign wake_mode = (CHIP_MODE == `MODE_SLEEP) ||
                     (CHIP_MODE == `MODE_FAILSAFE);
  assign lvl_mode = irq_mode || (CHIP_MODE == `MODE_INIT);

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  // The first stage feeds only the second stage.
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      gpio_meta_r <= 1'b0;
      gpio_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= WAKE_COMP;
      pin_sync_r <= pin_meta_r;
      gpio_meta_r <= GPIO_COMP;
      gpio_sync_r <= gpio_meta_r;
    end
  end

  // --------------------------------------------------------------------
  // Static sense glitch filters
  // --------------------------------------------------------------------
  // The filters keep running while measuring, so leaving measurement
  // does not replay a crossing that happened meanwhile.
  assign pin_diff = pin_sync_r != pin_stable_r;
  assign gpio_diff = gpio_sync_r != gpio_stable_r;
  // Either direction of change counts as an edge
  assign static_evt = filt_done(pin_diff, pin_cnt_r);
  assign gpio_evt = filt_done(gpio_diff, gpio_cnt_r);

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_cnt_r <= {`FILT_W{1'b0}};
      gpio_cnt_r <= {`FILT_W{1'b0}};
      pin_stable_r <= 1'b0;
      gpio_stable_r <= 1'b0;
    end else begin
      pin_cnt_r <= filt_next(pin_diff, pin_cnt_r);
      gpio_cnt_r <= filt_next(gpio_diff, gpio_cnt_r);
      if (static_evt) begin
        pin_stable_r <= pin_sync_r;
      end
      if (gpio_evt) begin
        gpio_stable_r <= gpio_sync_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // Cyclic sense sampling
  // --------------------------------------------------------------------
  // Sample on the first edge that sees HS_ON low after each on-phase, when the sensed network
  // has had the longest time to settle.
  assign sample_now = hs_on_d_r && !HS_ON;
  assign cyclic_evt = sample_now && sample_valid_r &&
                      (pin_sync_r != sample_r);

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hs_on_d_r <= 1'b0;
      sample_r <= 1'b0;
      sample_valid_r <= 1'b0;
    end else begin
      hs_on_d_r <= HS_ON;
      if (!cyclic || meas) begin
        sample_valid_r <= 1'b0;
      end else if (sample_now) begin
        sample_r <= pin_sync_r;
        sample_valid_r <= 1'b1;
      end
    end
  end

  // Measurement gates the internal wake signal before any event logic
  assign pin_evt = !meas && (cyclic ? cyclic_evt : static_evt);
  assign sense_level = cyclic ? sample_r : pin_stable_r;

  // A source only counts once it is enabled for wake
  assign pin_wake = pin_evt && pin_wake_en;
  assign gpio_wake = gpio_evt && gpio_wake_en;
  assign any_wake = pin_wake || gpio_wake;
  // Measuring leaves the pin unusable, so with no other source a sleep
  // attempt could never wake again; it is refused instead.
  assign sleep_refused = SLEEP_REQ && meas && ctl_r[`CTL_PIN_WAKE_EN] &&
                         !OTHER_WAKE_EN && !gpio_wake_en;

  // --------------------------------------------------------------------
  // Bus access
  // --------------------------------------------------------------------
  // A request is acknowledged one cycle after it is seen; effects happen
  // on the acknowledging edge.
  assign access = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign wr_take = AVS_WRITE && !AVS_WAITREQUEST;
  assign wr_lane = wr_take && AVS_BYTEENABLE[0];
  // Status bits clear by writing a one to bit zero of their address
  assign clr_first = wr_lane && AVS_WRITEDATA[0] &&
                     (AVS_ADDRESS == `ADDR_WAKE_STAT_FIRST);
  assign clr_second = wr_lane && AVS_WRITEDATA[0] &&
                      (AVS_ADDRESS == `ADDR_WAKE_STAT_SECOND);
  assign clr_err = wr_lane && AVS_WRITEDATA[0] &&
                   (AVS_ADDRESS == `ADDR_CMD_ERR);

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      if (access) begin
        AVS_WAITREQUEST <= 1'b1;
      end else if (AVS_READ || AVS_WRITE) begin
        AVS_WAITREQUEST <= 1'b0;
      end
      // Latched on first sight of a read, so it stands while acknowledged
      if (AVS_READ && AVS_WAITREQUEST) begin
        if (AVS_ADDRESS == `ADDR_WAKE_CONTROL) begin
          AVS_READDATA <= {27'h0000000, ctl_r};
        end else if (AVS_ADDRESS == `ADDR_BIAS_CONTROL) begin
          AVS_READDATA <= {30'h00000000, bias_r};
        end else if (AVS_ADDRESS == `ADDR_WAKE_STAT_FIRST) begin
          AVS_READDATA <= {31'h00000000, pin_flag_r};
        end else if (AVS_ADDRESS == `ADDR_WAKE_STAT_SECOND) begin
          AVS_READDATA <= {31'h00000000, gpio_flag_r};
        end else if (AVS_ADDRESS == `ADDR_LEVEL_STAT) begin
          AVS_READDATA <= {31'h00000000, level_r};
        end else if (AVS_ADDRESS == `ADDR_CMD_ERR) begin
          AVS_READDATA <= {31'h00000000, cmd_err_r};
        end else begin
          AVS_READDATA <= 32'h0000_0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_r <= `CTL_RESET;
      bias_r <= `BIAS_RESET;
    end else if (wr_lane) begin
      // Writes land even in measurement mode
      if (AVS_ADDRESS == `ADDR_WAKE_CONTROL) begin
        ctl_r <= AVS_WRITEDATA[`CTL_WIDTH-1:0];
      end else if (AVS_ADDRESS == `ADDR_BIAS_CONTROL) begin
        bias_r <= AVS_WRITEDATA[`BIAS_WIDTH-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  // Write one clears; a new event in the same cycle keeps the flag set.
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_flag_r <= 1'b0;
      gpio_flag_r <= 1'b0;
      cmd_err_r <= 1'b0;
    end else begin
      if (pin_wake) begin
        pin_flag_r <= 1'b1;
      end else if (clr_first) begin
        pin_flag_r <= 1'b0;
      end
      if (gpio_wake) begin
        gpio_flag_r <= 1'b1;
      end else if (clr_second) begin
        gpio_flag_r <= 1'b0;
      end
      if (sleep_refused) begin
        cmd_err_r <= 1'b1;
      end else if (clr_err) begin
        cmd_err_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Level status
  // --------------------------------------------------------------------
  // Outside the reporting modes the last value is simply held.
  // Measurement wins over mode so the bits read as cleared at any time.
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      level_r <= 1'b0;
    end else if (meas) begin
      level_r <= 1'b0;
    end else if (lvl_mode) begin
      level_r <= sense_level;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Event pulses are one cycle long; the interrupt generator stretches them.
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      WAKE_IRQ <= 1'b0;
      WAKE_UP <= 1'b0;
      RESTART_REQ <= 1'b0;
      PULL_UP_EN <= 1'b0;
      PULL_DOWN_EN <= 1'b0;
      FAIL_OUT_DISABLE <= 1'b0;
      GPIO_DISABLE <= 1'b0;
    end else begin
      WAKE_IRQ <= irq_mode && any_wake;
      WAKE_UP <= wake_mode && any_wake;
      RESTART_REQ <= sleep_refused;
      FAIL_OUT_DISABLE <= meas;
      GPIO_DISABLE <= meas;
      if (meas) begin
        PULL_UP_EN <= 1'b0;
        PULL_DOWN_EN <= 1'b0;
      end else if (bias_r == `BIAS_PULL_DOWN) begin
        PULL_UP_EN <= 1'b0;
        PULL_DOWN_EN <= 1'b1;
      end else if (bias_r == `BIAS_PULL_UP) begin
        PULL_UP_EN <= 1'b1;
        PULL_DOWN_EN <= 1'b0;
      end else if (bias_r == `BIAS_AUTO) begin
        // The chosen source reinforces the level the line already holds
        PULL_UP_EN <= pin_sync_r;
        PULL_DOWN_EN <= !pin_sync_r;
      end else begin
        PULL_UP_EN <= 1'b0;
        PULL_DOWN_EN <= 1'b0;
      end
    end
  end

endmodule

//--- verilog/hv_wake_map.vh
// Register map, field positions and timing constants of the wake monitor
`ifndef HV_WAKE_MAP_VH
`define HV_WAKE_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_WAKE_CONTROL 4'h0
`define ADDR_BIAS_CONTROL 4'h4
`define ADDR_WAKE_STAT_FIRST 4'h8
`define ADDR_WAKE_STAT_SECOND 4'hc
// Level and command-error status sit on odd bytes, since all four word addresses are taken
`define ADDR_LEVEL_STAT 4'h1
`define ADDR_CMD_ERR 4'h3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_PIN_WAKE_EN 0
`define CTL_GPIO_WAKE_EN 1
`define CTL_CYCLIC_SEL 2
`define CTL_MEAS_EN 3
`define CTL_GPIO_AS_WAKE 4
`define CTL_WIDTH 5
`define BIAS_WIDTH 2

// ----------------------------------------------------------------------
// Reset values and bias encodings
// ----------------------------------------------------------------------
`define CTL_RESET 5'h00
`define BIAS_RESET 2'h0
`define BIAS_NONE 2'h0
`define BIAS_PULL_DOWN 2'h1
`define BIAS_PULL_UP 2'h2
`define BIAS_AUTO 2'h3

// ----------------------------------------------------------------------
// Chip mode codes
// ----------------------------------------------------------------------
`define MODE_NORMAL 3'h0
`define MODE_STOP 3'h1
`define MODE_INIT 3'h2
`define MODE_SLEEP 3'h3
`define MODE_FAILSAFE 3'h4
`define MODE_RESTART 3'h5

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define FILTER_TIME_NS 16000
`define FILT_CYCLES ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_W 10

`endif

//--- tb/hv_wake_chk.sv
// Port-level assertions for the wake input monitor
`timescale 1ns/1ps
`include "hv_wake_map.vh"
module hv_wake_chk (
  input wire CLOCK,
  input wire RESETN,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  input wire AVS_WAITREQUEST,
  input wire WAKE_COMP,
  input wire [2:0] CHIP_MODE,
  input wire SLEEP_REQ,
  input wire OTHER_WAKE_EN,
  input wire PULL_UP_EN,
  input wire PULL_DOWN_EN,
  input wire WAKE_IRQ,
  input wire WAKE_UP,
  input wire RESTART_REQ,
  input wire FAIL_OUT_DISABLE,
  input wire GPIO_DISABLE
);
  // ----------------------------------------------------------------
  // Shadow of the written settings and a pin quiet-time counter
  // ----------------------------------------------------------------
  localparam int LO = `FILT_CYCLES - 5;
  localparam int HI = `FILT_CYCLES + 12;
  reg [4:0] ctl_r;
  reg [1:0] bias_r;
  reg [1:0] q_r;
  reg [9:0] still_r;
  reg pin_r;
  wire wr_ack = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  // Outputs are registered, so settings count only once they have settled
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_r <= 5'h00;
      bias_r <= 2'h0;
      q_r <= 2'h0;
      still_r <= 10'h000;
      pin_r <= 1'b0;
    end else begin
      pin_r <= WAKE_COMP;
      if (WAKE_COMP != pin_r)
        still_r <= 10'h000;
      else if (still_r != 10'h3ff)
        still_r <= still_r + 10'h001;
      if (wr_ack)
        q_r <= 2'h0;
      else if (q_r != 2'h3)
        q_r <= q_r + 2'h1;
      if (wr_ack && AVS_ADDRESS == `ADDR_WAKE_CONTROL)
        ctl_r <= AVS_WRITEDATA[4:0];
      if (wr_ack && AVS_ADDRESS == `ADDR_BIAS_CONTROL)
        bias_r <= AVS_WRITEDATA[1:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence s_cfg_still; q_r == 2'h3; endsequence
  sequence s_evt; WAKE_IRQ || WAKE_UP; endsequence
  sequence s_req_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
  a_ack_latency: assert property (s_req_wait |=> !AVS_WAITREQUEST)
    else $error("bus answer not one cycle after request");
  a_meas_outs: assert property (s_cfg_still |->
    FAIL_OUT_DISABLE == ctl_r[3] && GPIO_DISABLE == ctl_r[3])
    else $error("disable outputs do not follow measurement enable");
  a_meas_bias: assert property (s_cfg_still ##0 ctl_r[3] |->
    !PULL_UP_EN && !PULL_DOWN_EN) else $error("bias on while measuring");
  a_bias_fixed: assert property (s_cfg_still ##0
    (!ctl_r[3] && bias_r != `BIAS_AUTO) |->
    PULL_UP_EN == (bias_r == `BIAS_PULL_UP) &&
    PULL_DOWN_EN == (bias_r == `BIAS_PULL_DOWN))
    else $error("bias sources differ from bias field");
  a_bias_auto: assert property ($stable(WAKE_COMP)[*4] ##0
    s_cfg_still ##0 (!ctl_r[3] && bias_r == `BIAS_AUTO) |->
    PULL_UP_EN == WAKE_COMP && PULL_DOWN_EN == !WAKE_COMP)
    else $error("automatic bias does not follow pin level");
  a_evt_mode: assert property (s_evt |->
    (WAKE_IRQ && (CHIP_MODE == `MODE_NORMAL || CHIP_MODE == `MODE_STOP)) ||
    (WAKE_UP && (CHIP_MODE == `MODE_SLEEP || CHIP_MODE == `MODE_FAILSAFE)))
    else $error("event signalled in wrong chip mode");
  a_evt_gated: assert property (s_evt |-> !ctl_r[3] &&
    (ctl_r[0] || (ctl_r[1] && ctl_r[4])))
    else $error("event while wake disabled or measuring");
  a_filter_time: assert property (s_evt ##0
    (ctl_r[0] && !ctl_r[2] && !ctl_r[4]) |-> still_r >= LO && still_r <= HI)
    else $error("event not one filter interval after last crossing");
  a_restart: assert property (RESTART_REQ |-> $past(SLEEP_REQ) &&
    ctl_r[3] && ctl_r[0] && !OTHER_WAKE_EN)
    else $error("restart without sleep attempt in measurement");
endmodule
bind hv_wake_input_monitor hv_wake_chk u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .WAKE_COMP(WAKE_COMP),
  .CHIP_MODE(CHIP_MODE), .SLEEP_REQ(SLEEP_REQ), .OTHER_WAKE_EN(OTHER_WAKE_EN),
  .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .WAKE_IRQ(WAKE_IRQ),
  .WAKE_UP(WAKE_UP), .RESTART_REQ(RESTART_REQ),
  .FAIL_OUT_DISABLE(FAIL_OUT_DISABLE), .GPIO_DISABLE(GPIO_DISABLE));

//--- tb/wake_line_model.sv
// Model of the switch or signal line at the high-voltage wake pin
`timescale 1ns/1ps
module wake_line_model (
  input wire CLOCK,
  input wire drv_en,
  input wire drv_lvl,
  input wire pu,
  input wire pd,
  output wire comp
);
  // An open line with no bias source wanders, so it never looks stable
  logic float_r = 1'b0;
  always @(posedge CLOCK) float_r <= !float_r;
  assign comp = drv_en ? drv_lvl : pu ? 1'b1 : pd ? 1'b0 : float_r;
endmodule

//--- tb/testbench.sv
// Self-checking bench of the wake input monitor
`timescale 1ns/1ps
`include "hv_wake_map.vh"
module testbench;
  // ----------------------------------------------------------------
  // Signals, design and line model
  // ----------------------------------------------------------------
  logic CLOCK = 1'b0, RESETN = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_WRITEDATA = 32'h0, rd;
  logic GPIO_COMP = 1'b0, HS_ON = 1'b0, SLEEP_REQ = 1'b0;
  logic OTHER_WAKE_EN = 1'b0, drv_en = 1'b1, drv_lvl = 1'b0;
  logic [2:0] CHIP_MODE = `MODE_NORMAL;
  wire [31:0] AVS_READDATA;
  wire AVS_WAITREQUEST, WAKE_COMP, PULL_UP_EN, PULL_DOWN_EN, WAKE_IRQ;
  wire WAKE_UP, RESTART_REQ, FAIL_OUT_DISABLE, GPIO_DISABLE;
  int error_cnt = 0, n_compared = 0, cyc = 0, first, n_irq, n_wu, n_rst;
  typedef struct {logic [3:0] a; logic [31:0] d, r; logic [3:0] o;} row_t;
  // Output column is {gpio off, fail out off, pull-up, pull-down}
  row_t rows [8] = '{'{4'h4, 0, 0, 4'h0}, '{4'h4, 1, 1, 4'h1},
    '{4'h4, 2, 2, 4'h2}, '{4'h4, 3, 3, 4'h1}, '{4'h0, 8, 8, 4'hc},
    '{4'h4, 2, 2, 4'hc}, '{4'h0, 1, 1, 4'h2}, '{4'h2, '1, 0, 4'h2}};
  logic [2:0] modes [4] = '{`MODE_NORMAL, `MODE_STOP, `MODE_SLEEP,
    `MODE_FAILSAFE};
  hv_wake_input_monitor dut (.CLOCK(CLOCK), .RESETN(RESETN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .WAKE_COMP(WAKE_COMP), .GPIO_COMP(GPIO_COMP), .HS_ON(HS_ON),
    .CHIP_MODE(CHIP_MODE), .SLEEP_REQ(SLEEP_REQ),
    .OTHER_WAKE_EN(OTHER_WAKE_EN), .PULL_UP_EN(PULL_UP_EN),
    .PULL_DOWN_EN(PULL_DOWN_EN), .WAKE_IRQ(WAKE_IRQ), .WAKE_UP(WAKE_UP),
    .RESTART_REQ(RESTART_REQ), .FAIL_OUT_DISABLE(FAIL_OUT_DISABLE),
    .GPIO_DISABLE(GPIO_DISABLE));
  wake_line_model line (.CLOCK(CLOCK), .drv_en(drv_en), .drv_lvl(drv_lvl),
    .pu(PULL_UP_EN), .pd(PULL_DOWN_EN), .comp(WAKE_COMP));
  initial forever #10 CLOCK = !CLOCK;
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict;
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task print_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_win(input int t);
    n_compared++;
    if (t < `FILT_CYCLES - 5 || t > `FILT_CYCLES + 12) begin
      error_cnt++;
      $display("ERROR %0t event after %0d cycles", $time, t);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // Holds the request until the edge that samples waitrequest low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
    int k;
    k = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge CLOCK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge CLOCK);
      k++;
    end
    chk(k, 1);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task rdchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 0, 4'hf);
    chk(rd, e);
  endtask
  task watch(input int n);
    first = -1;
    n_irq = 0;
    n_wu = 0;
    n_rst = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge CLOCK);
      if (first < 0 && (WAKE_IRQ | WAKE_UP) === 1'b1) first = i;
      n_irq += int'(WAKE_IRQ === 1'b1);
      n_wu += int'(WAKE_UP === 1'b1);
      n_rst += int'(RESTART_REQ === 1'b1);
    end
  endtask
  task sleep_try(input logic other);
    OTHER_WAKE_EN <= other;
    SLEEP_REQ <= 1'b1;
    tick(1);
    SLEEP_REQ <= 1'b0;
    watch(4);
  endtask
  task hs_pulse;
    HS_ON <= 1'b1;
    tick(5);
    HS_ON <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(5);
    chk({AVS_WAITREQUEST, PULL_UP_EN, PULL_DOWN_EN, WAKE_IRQ, WAKE_UP,
      RESTART_REQ, FAIL_OUT_DISABLE, GPIO_DISABLE}, 8'h80);
    tick(5);
    RESETN <= 1'b1;
    tick(1);
    for (int i = 0; i < 16; i += 4) rdchk(i, 0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].r);
      tick(3);
      chk({GPIO_DISABLE, FAIL_OUT_DISABLE, PULL_UP_EN, PULL_DOWN_EN},
        rows[i].o);
    end
    bus(1'b1, `ADDR_WAKE_CONTROL, 32'h8, 4'he);
    rdchk(`ADDR_WAKE_CONTROL, 1);
    for (int i = 0; i < 4; i++) begin
      CHIP_MODE <= modes[i];
      drv_lvl <= !drv_lvl;
      watch(900);
      chk(n_irq, i < 2);
      chk(n_wu, i >= 2);
      chk_win(first);
      rdchk(`ADDR_WAKE_STAT_FIRST, 1);
      wr(`ADDR_WAKE_STAT_FIRST, 1);
      rdchk(`ADDR_WAKE_STAT_FIRST, 0);
    end
    CHIP_MODE <= `MODE_NORMAL;
    drv_lvl <= 1'b1;
    watch(500);
    chk(n_irq, 0);
    drv_lvl <= 1'b0;
    tick(20);
    drv_lvl <= 1'b1;
    watch(900);
    chk(n_irq, 1);
    chk_win(first);
    rdchk(`ADDR_LEVEL_STAT, 1);
    drv_lvl <= 1'b0;
    tick(300);
    drv_lvl <= 1'b1;
    watch(1000);
    chk(n_irq, 0);
    wr(`ADDR_WAKE_STAT_FIRST, 1);
    wr(`ADDR_WAKE_CONTROL, 0);
    drv_lvl <= 1'b0;
    watch(900);
    chk(n_irq, 0);
    rdchk(`ADDR_WAKE_STAT_FIRST, 0);
    wr(`ADDR_WAKE_CONTROL, 9);
    drv_lvl <= 1'b1;
    watch(900);
    chk(n_irq + n_wu, 0);
    rdchk(`ADDR_WAKE_STAT_FIRST, 0);
    rdchk(`ADDR_LEVEL_STAT, 0);
    sleep_try(1'b0);
    chk(n_rst, 1);
    rdchk(`ADDR_CMD_ERR, 1);
    sleep_try(1'b1);
    chk(n_rst, 0);
    drv_lvl <= 1'b0;
    tick(2);
    wr(`ADDR_WAKE_CONTROL, 32'h12);
    GPIO_COMP <= 1'b1;
    watch(900);
    chk_win(first);
    rdchk(`ADDR_WAKE_STAT_SECOND, 1);
    wr(`ADDR_BIAS_CONTROL, 3);
    drv_lvl <= 1'b1;
    tick(10);
    drv_en <= 1'b0;
    tick(10);
    chk({WAKE_COMP, PULL_UP_EN, PULL_DOWN_EN}, 3'b110);
    drv_en <= 1'b1;
    wr(`ADDR_BIAS_CONTROL, 0);
    wr(`ADDR_WAKE_CONTROL, 5);
    hs_pulse;
    watch(6);
    chk(n_irq, 0);
    drv_lvl <= 1'b0;
    watch(20);
    chk(n_irq, 0);
    hs_pulse;
    watch(6);
    chk(n_irq, 1);
    rdchk(`ADDR_LEVEL_STAT, 0);
    print_verdict;
  end
endmodule
